// ==== cbr_pkg.sv ====
/*
 Shared constants for the processor bus glue: state codes, cycle types,
 restart opcode layout and reset values.
 Assumes the processor state and cycle encodings below match the part.
*/
`default_nettype none
package cbr_pkg;
   // ************************************************************
   // Processor state code values
   // ************************************************************
   localparam logic [2:0] ST_WAIT  = 3'h0;
   localparam logic [2:0] ST_T2    = 3'h1;
   localparam logic [2:0] ST_T1    = 3'h2;
   localparam logic [2:0] ST_ACK   = 3'h3;
   localparam logic [2:0] ST_T3    = 3'h4;
   localparam logic [2:0] ST_T5    = 3'h5;
   localparam logic [2:0] ST_HALT  = 3'h6;
   localparam logic [2:0] ST_T4    = 3'h7;

   // ************************************************************
   // Decoded timing state
   // ************************************************************
   typedef enum {
      CBR_T1, CBR_T2, CBR_T3, CBR_T4, CBR_T5,
      CBR_ACK, CBR_HALT, CBR_WAIT
   } cbr_state_t;

   // ************************************************************
   // Cycle type bits (bit 7, bit 6)
   // ************************************************************
   localparam logic [1:0] CYC_FETCH = 2'h0;
   localparam logic [1:0] CYC_READ  = 2'h1;
   localparam logic [1:0] CYC_PORT  = 2'h2;
   localparam logic [1:0] CYC_WRITE = 2'h3;
   localparam int         CYC_POS   = 6;
   localparam int         HIGH_BITS = 6;

   // ************************************************************
   // Restart opcode layout: 00 aaa 101
   // ************************************************************
   localparam logic [2:0] RST_LOW   = 3'h5;
   localparam logic [1:0] RST_TOP   = 2'h0;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0]  RST_BYTE   = 8'h00;
   localparam logic [13:0] RST_ADDR   = 14'h0000;
   localparam logic [1:0]  RST_CYCLE  = 2'h0;
endpackage
`default_nettype wire

// ==== cbr_bus_glue.sv ====
/*
 Processor bus glue: state decode, address latches, bus gating, strobes
 and the restart interrupt controller.
 Assumes every input is synchronous to clk, the processor clocks are
 slow against clk, and bus wires are resolved outside from the enables.
*/
`timescale 1ns/10ps
`default_nettype none
module cbr_bus_glue #(
   parameter int ADDR_W = 14
) (
   input  wire  logic              clk,
   input  wire  logic              rstn,
   input  wire  logic [2:0]        state_code,
   input  wire  logic              half_state_marker,
   input  wire  logic              phase_two_clock,
   input  wire  logic              read_clock,
   input  wire  logic              read_instr,
   input  wire  logic [7:0]        cpu_data_out,
   input  wire  logic [7:0]        input_bus,
   input  wire  logic              processor_owns_bus,
   input  wire  logic              foreign_master_n,
   input  wire  logic              ext_irq_n,
   input  wire  logic              power_on_clear,
   input  wire  logic              slow_tick,
   input  wire  logic [2:0]        restart_select_n,
   output var   logic [7:0]        timing_state,
   output var   logic [ADDR_W-1:0] address_bus_out,
   output var   logic              address_bus_oe,
   output var   logic [1:0]        cycle_type_bits,
   output var   logic              port_cycle_n,
   output var   logic [7:0]        cpu_data_in,
   output var   logic              input_enable,
   output var   logic [7:0]        output_bus,
   output var   logic              output_bus_oe,
   output var   logic              cpu_interrupt,
   output var   logic              cpu_ready,
   output var   logic              realigned_half_marker_n,
   output var   logic              fetch_strobe_n,
   output var   logic              mem_direction,
   output var   logic              interrupt_sample_strobe
);

   // ************************************************************
   // State decode
   // ************************************************************
   cbr_pkg::cbr_state_t state;
   cbr_pkg::cbr_state_t prev_state;
   logic                in_t2_or_wait;
   logic                late_t2_or_wait;
   logic                is_t3;
   logic                owns;

   always_comb begin
      case (state_code)
         cbr_pkg::ST_T1:   state = cbr_pkg::CBR_T1;
         cbr_pkg::ST_T2:   state = cbr_pkg::CBR_T2;
         cbr_pkg::ST_T3:   state = cbr_pkg::CBR_T3;
         cbr_pkg::ST_T4:   state = cbr_pkg::CBR_T4;
         cbr_pkg::ST_T5:   state = cbr_pkg::CBR_T5;
         cbr_pkg::ST_ACK:  state = cbr_pkg::CBR_ACK;
         cbr_pkg::ST_HALT: state = cbr_pkg::CBR_HALT;
         default:          state = cbr_pkg::CBR_WAIT;
      endcase
   end

   assign in_t2_or_wait   = (state == cbr_pkg::CBR_T2) || (state == cbr_pkg::CBR_WAIT);
   assign late_t2_or_wait = in_t2_or_wait && half_state_marker;
   assign is_t3           = (state == cbr_pkg::CBR_T3);
   assign owns            = processor_owns_bus && foreign_master_n;

   // Previous state for entry and exit detection
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prev_state <= cbr_pkg::CBR_T1;
      end else begin
         prev_state <= state;
      end
   end

   logic enter_ack;
   logic enter_halt;
   logic enter_t3;
   logic leave_t3;

   assign enter_ack  = (state == cbr_pkg::CBR_ACK) && (prev_state != cbr_pkg::CBR_ACK);
   assign enter_halt = (state == cbr_pkg::CBR_HALT) && (prev_state != cbr_pkg::CBR_HALT);
   assign enter_t3   = is_t3 && (prev_state != cbr_pkg::CBR_T3);
   assign leave_t3   = !is_t3 && (prev_state == cbr_pkg::CBR_T3);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         timing_state <= cbr_pkg::RST_BYTE;
      end else begin
         timing_state <= 8'h01 << state;
      end
   end

   // ************************************************************
   // Address latches
   // ************************************************************
   localparam int HIGH_W = cbr_pkg::HIGH_BITS;
   logic [7:0]          addr_low;
   logic [HIGH_W-1:0]   addr_high;
   logic [7:0]          next_low;
   logic [HIGH_W-1:0]   next_high;

   // Bus shows a captured byte in the same clock as its latch
   assign next_low  = ((state == cbr_pkg::CBR_T1) || (state == cbr_pkg::CBR_ACK)) ?
                      cpu_data_out : addr_low;
   assign next_high = (state == cbr_pkg::CBR_T2) ? cpu_data_out[HIGH_W-1:0] : addr_high;

   // Low byte in T1 or acknowledge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         addr_low <= cbr_pkg::RST_BYTE;
      end else if ((state == cbr_pkg::CBR_T1) || (state == cbr_pkg::CBR_ACK)) begin
         addr_low <= cpu_data_out;
      end
   end

   // High bits and cycle type in T2
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         addr_high       <= cbr_pkg::RST_ADDR[HIGH_W-1:0];
         cycle_type_bits <= cbr_pkg::RST_CYCLE;
      end else if (state == cbr_pkg::CBR_T2) begin
         addr_high       <= cpu_data_out[HIGH_W-1:0];
         cycle_type_bits <= cpu_data_out[cbr_pkg::CYC_POS +: 2];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         address_bus_out <= cbr_pkg::RST_ADDR[ADDR_W-1:0];
         address_bus_oe  <= 1'b0;
      end else begin
         address_bus_out <= ADDR_W'({next_high, next_low});
         address_bus_oe  <= owns;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         port_cycle_n <= 1'b1;
      end else begin
         port_cycle_n <= (cycle_type_bits != cbr_pkg::CYC_PORT);
      end
   end

   // ************************************************************
   // Output data bus
   // ************************************************************
   // Drive only while owner and no foreign master
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         output_bus    <= cbr_pkg::RST_BYTE;
         output_bus_oe <= 1'b0;
      end else begin
         output_bus    <= cpu_data_out;
         output_bus_oe <= owns && (read_instr || late_t2_or_wait || is_t3);
      end
   end

   // ************************************************************
   // Strobes and reclocking
   // ************************************************************
   logic phase_two_prev;
   logic strobe_prev;
   logic strobe_lead;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         phase_two_prev <= 1'b0;
      end else begin
         phase_two_prev <= phase_two_clock;
      end
   end

   // Reclock marker on phase two rising edge
   // Marker may lag phase two by 700 ns, so take it at the next edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         realigned_half_marker_n <= 1'b1;
      end else if (phase_two_clock && !phase_two_prev) begin
         realigned_half_marker_n <= !half_state_marker;
      end
   end

   // Sample strobe NAND of marker and phase two
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         interrupt_sample_strobe <= 1'b1;
         strobe_prev             <= 1'b1;
      end else begin
         interrupt_sample_strobe <= !(half_state_marker && phase_two_clock);
         strobe_prev             <= interrupt_sample_strobe;
      end
   end

   // Leading edge is the fall of the active-low strobe
   assign strobe_lead = strobe_prev && !interrupt_sample_strobe;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fetch_strobe_n <= 1'b1;
      end else begin
         fetch_strobe_n <= !(read_clock && late_t2_or_wait);
      end
   end

   // Direction low only for memory writes
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mem_direction <= 1'b1;
      end else begin
         mem_direction <= !(is_t3 && half_state_marker &&
                            (cycle_type_bits == cbr_pkg::CYC_WRITE));
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cpu_ready <= 1'b1;
      end else begin
         cpu_ready <= 1'b1;
      end
   end

   // ************************************************************
   // Interrupt request sources
   // ************************************************************
   logic ext_prev;
   logic tick_prev;
   logic poc_waiting;
   logic poc_fire;
   logic poc_source;
   logic request;
   logic ack;
   logic restart_gate;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ext_prev  <= 1'b1;
         tick_prev <= 1'b1;
      end else begin
         ext_prev  <= ext_irq_n;
         tick_prev <= slow_tick;
      end
   end

   // Next low tick after clear fires power-on interrupt
   assign poc_fire = poc_waiting && !power_on_clear && tick_prev && !slow_tick;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         poc_waiting <= 1'b1;
      end else if (power_on_clear) begin
         poc_waiting <= 1'b1;
      end else if (poc_fire) begin
         poc_waiting <= 1'b0;
      end
   end

   // Remember power-on origin until restart is done
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         poc_source <= 1'b0;
      end else if (power_on_clear) begin
         poc_source <= 1'b0;
      end else if (poc_fire) begin
         poc_source <= 1'b1;
      end else if (restart_gate && leave_t3) begin
         poc_source <= 1'b0;
      end
   end

   // External edge, halt entry or power-on fire set it, set wins over the T3 clear
   // Cleared at end of T3, and by power-on clear
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         request <= 1'b0;
      end else if (power_on_clear) begin
         request <= 1'b0;
      end else if ((ext_prev && !ext_irq_n) || enter_halt || poc_fire) begin
         request <= 1'b1;
      end else if (leave_t3) begin
         request <= 1'b0;
      end
   end

   // Held until end of the acknowledge T3
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cpu_interrupt <= 1'b0;
      end else if (power_on_clear) begin
         cpu_interrupt <= 1'b0;
      end else if (strobe_lead && request) begin
         cpu_interrupt <= 1'b1;
      end else if (leave_t3 && restart_gate) begin
         cpu_interrupt <= 1'b0;
      end
   end

   // Set on acknowledge entry, cleared at T3 start
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ack <= 1'b0;
      end else if (power_on_clear) begin
         ack <= 1'b0;
      end else if (enter_ack) begin
         ack <= 1'b1;
      end else if (enter_t3) begin
         ack <= 1'b0;
      end
   end

   // Gate holds through the T3 that follows acknowledge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         restart_gate <= 1'b0;
      end else if (power_on_clear) begin
         restart_gate <= 1'b0;
      end else if (enter_t3) begin
         restart_gate <= ack;
      end else if (leave_t3) begin
         restart_gate <= 1'b0;
      end
   end

   // ************************************************************
   // Processor input path
   // ************************************************************
   logic [2:0] vector;
   logic [7:0] restart_op;

   // Eight vectors, lowest line forced inactive for power-on
   assign vector     = {restart_select_n[2:1], restart_select_n[0] | poc_source};
   assign restart_op = {cbr_pkg::RST_TOP, vector, cbr_pkg::RST_LOW};

   // Input only in T3; restart gates win while open
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         input_enable <= 1'b0;
         cpu_data_in  <= cbr_pkg::RST_BYTE;
      end else begin
         input_enable <= is_t3;
         if (!is_t3) begin
            cpu_data_in <= cbr_pkg::RST_BYTE;
         end else if (restart_gate || (ack && enter_t3)) begin
            cpu_data_in <= restart_op;
         end else begin
            cpu_data_in <= input_bus;
         end
      end
   end

endmodule
`default_nettype wire

// ==== cbr_chk.sv ====
/*
 Port checker for the processor bus glue.
 Assumes it is bound onto cbr_bus_glue and shares its single clock.
*/
`timescale 1ns/10ps
`default_nettype none
module cbr_chk #(
   parameter int ADDR_W = 14
) (
   input wire logic              clk,
   input wire logic              rstn,
   input wire logic [2:0]        state_code,
   input wire logic              half_state_marker,
   input wire logic              phase_two_clock,
   input wire logic              read_clock,
   input wire logic              read_instr,
   input wire logic [7:0]        cpu_data_out,
   input wire logic [7:0]        input_bus,
   input wire logic              processor_owns_bus,
   input wire logic              foreign_master_n,
   input wire logic              ext_irq_n,
   input wire logic              power_on_clear,
   input wire logic              slow_tick,
   input wire logic [2:0]        restart_select_n,
   input wire logic [7:0]        timing_state,
   input wire logic [ADDR_W-1:0] address_bus_out,
   input wire logic              address_bus_oe,
   input wire logic [1:0]        cycle_type_bits,
   input wire logic              port_cycle_n,
   input wire logic [7:0]        cpu_data_in,
   input wire logic              input_enable,
   input wire logic [7:0]        output_bus,
   input wire logic              output_bus_oe,
   input wire logic              cpu_interrupt,
   input wire logic              cpu_ready,
   input wire logic              realigned_half_marker_n,
   input wire logic              fetch_strobe_n,
   input wire logic              mem_direction,
   input wire logic              interrupt_sample_strobe
);
   // ********************************
   // Bus and strobe relations
   // ********************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   wire logic own = processor_owns_bus && foreign_master_n;

   AST_DECODE: assert property ((state_code == cbr_pkg::ST_ACK) |=> (timing_state == 8'h20))
      else $error("ack state not decoded");
   AST_LOW_ADDR: assert property ((state_code == cbr_pkg::ST_T1 || state_code == cbr_pkg::ST_ACK)
      |=> (address_bus_out[7:0] == $past(cpu_data_out))) else $error("low address not latched");
   AST_HIGH_ADDR: assert property ((state_code == cbr_pkg::ST_T2) |=>
      (address_bus_out[ADDR_W-1:8] == $past(cpu_data_out[5:0])
      && cycle_type_bits == $past(cpu_data_out[7:6]))) else $error("high address not latched");
   AST_PORT: assert property (1'b1 |=>
      (port_cycle_n == ($past(cycle_type_bits) != cbr_pkg::CYC_PORT))) else $error("port flag wrong");
   AST_INPUT_EN: assert property (1'b1 |=>
      (input_enable == $past(state_code == cbr_pkg::ST_T3))) else $error("input enable wrong");
   AST_RELEASE: assert property (!own |=> (!address_bus_oe && !output_bus_oe))
      else $error("bus not released");
   AST_ADDR_OE: assert property (own |=> address_bus_oe)
      else $error("address drivers off");
   AST_OUT_OE: assert property ((own && state_code == cbr_pkg::ST_T3) |=> output_bus_oe)
      else $error("output drivers off in transfer");
   AST_READY: assert property (cpu_ready)
      else $error("ready dropped");
   AST_FETCH: assert property ((read_clock && half_state_marker
      && (state_code == cbr_pkg::ST_T2 || state_code == cbr_pkg::ST_WAIT)) |=> !fetch_strobe_n)
      else $error("fetch strobe missing");
   AST_DIR: assert property ((state_code == cbr_pkg::ST_T3 && half_state_marker
      && cycle_type_bits == cbr_pkg::CYC_WRITE) |=> !mem_direction) else $error("direction wrong");
   AST_STROBE: assert property (1'b1 |=>
      (interrupt_sample_strobe == !$past(half_state_marker && phase_two_clock)))
      else $error("sample strobe wrong");
   // Interrupt only right after a strobe fall
   AST_INT_RISE: assert property ($rose(cpu_interrupt) |->
      (!$past(interrupt_sample_strobe) && $past(interrupt_sample_strobe, 2)))
      else $error("interrupt rose without strobe");
endmodule
`default_nettype wire

// ==== cbr_cpu_model.sv ====
/*
 Processor side clocks: phase two, half marker, read clock, slow tick.
 Assumes a 25 MHz bench clock; counts are shortened for simulation.
*/
`timescale 1ns/10ps
`default_nettype none
module cbr_cpu_model #(
   parameter int PH_LEN   = 34,
   parameter int TICK_LEN = 200
) (
   input  wire logic clk,
   output wire logic phase_two_clock,
   output wire logic half_state_marker,
   output wire logic read_clock,
   output wire logic slow_tick
);
   int ph_cnt   = 0;
   int tick_cnt = 0;
   always @(negedge clk) begin
      ph_cnt <= (ph_cnt == PH_LEN - 1) ? 0 : ph_cnt + 1;
      tick_cnt <= (tick_cnt == TICK_LEN - 1) ? 0 : tick_cnt + 1;
   end
   assign phase_two_clock = ph_cnt < 8;
   // Marker leads phase two, straddles its rise
   assign half_state_marker = ph_cnt >= 26 || ph_cnt < 10;
   assign read_clock = ph_cnt < 17;
   assign slow_tick = tick_cnt != 0;
endmodule
`default_nettype wire

// ==== tb.sv ====
/*
 Self-checking bench for the processor bus glue.
 Assumes the design and checker files are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam int ADDR_W = 14;
   logic              clk, rstn, half_state_marker, phase_two_clock, read_clock, read_instr;
   logic              processor_owns_bus, foreign_master_n, ext_irq_n, power_on_clear, slow_tick;
   logic              address_bus_oe, port_cycle_n, input_enable, output_bus_oe, cpu_interrupt;
   logic              cpu_ready, realigned_half_marker_n, fetch_strobe_n, mem_direction;
   logic              interrupt_sample_strobe;
   logic [1:0]        cycle_type_bits;
   logic [2:0]        state_code, restart_select_n;
   logic [7:0]        cpu_data_out, input_bus, timing_state, cpu_data_in, output_bus;
   logic [ADDR_W-1:0] address_bus_out;
   int                n_mismatch, comparisons;

   cbr_bus_glue #(.ADDR_W(ADDR_W)) uut (.*);
   cbr_cpu_model cpu (.clk(clk), .phase_two_clock(phase_two_clock),
      .half_state_marker(half_state_marker), .read_clock(read_clock), .slow_tick(slow_tick));

   // ********************************
   // Shared tasks
   // ********************************
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict;
      if (n_mismatch == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic step(input logic [2:0] code, input logic [7:0] data);
      state_code = code;
      cpu_data_out = data;
      @(negedge clk);
   endtask
   // Marker and phase two both high, so the next edge sees the marker
   task automatic wait_window;
      while (!(half_state_marker === 1'b1 && phase_two_clock === 1'b1))
         @(negedge clk);
   endtask
   task automatic irq_seq(input logic [2:0] rs, input logic [7:0] exp);
      int n;
      restart_select_n = rs;
      n = 0;
      while (cpu_interrupt !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      check("irq", 16'(cpu_interrupt), 16'h1);
      step(cbr_pkg::ST_ACK, 8'h00);
      check("ack decode", 16'(timing_state), 16'h20);
      step(cbr_pkg::ST_T3, 8'h00);
      step(cbr_pkg::ST_T3, 8'h00);
      check("restart", 16'(cpu_data_in), 16'(exp));
      check("held", 16'(cpu_interrupt), 16'h1);
      step(cbr_pkg::ST_T4, 8'h00);
      step(cbr_pkg::ST_T4, 8'h00);
      check("irq clear", 16'(cpu_interrupt), 16'h0);
      check("gate shut", 16'(cpu_data_in), 16'h0);
   endtask

   // ********************************
   // Scenarios
   // ********************************
   task automatic t_bus;
      int c;
      for (c = 0; c < 4; c++) begin
         step(cbr_pkg::ST_T1, 8'hA5 ^ 8'(c));
         check("low addr", 16'(address_bus_out[7:0]), 16'(8'hA5 ^ 8'(c)));
         wait_window;
         step(cbr_pkg::ST_T2, {2'(c), 6'h2A});
         check("fetch", 16'(fetch_strobe_n), 16'h0);
         check("cycle", 16'(cycle_type_bits), 16'(c));
         check("addr", 16'(address_bus_out), {2'h0, 6'h2A, 8'hA5 ^ 8'(c)});
         wait_window;
         input_bus = 8'h3C ^ 8'(c);
         step(cbr_pkg::ST_T3, 8'h00);
         check("in en", 16'(input_enable), 16'h1);
         check("data in", 16'(cpu_data_in), 16'(8'h3C ^ 8'(c)));
         check("direction", 16'(mem_direction), 16'(c != 3));
         check("out oe", 16'(output_bus_oe), 16'h1);
         step(cbr_pkg::ST_T4, 8'h00);
         check("port", 16'(port_cycle_n), 16'(c != 2));
         check("in off", 16'(input_enable), 16'h0);
      end
      check("realign", 16'(realigned_half_marker_n), 16'h0);
   endtask
   task automatic t_own;
      int k;
      read_instr = 1'b1;
      for (k = 0; k < 4; k++) begin
         processor_owns_bus = k[0];
         foreign_master_n = k[1];
         step(cbr_pkg::ST_T4, 8'h5A);
         check("addr oe", 16'(address_bus_oe), 16'(k == 3));
         check("out oe", 16'(output_bus_oe), 16'(k == 3));
         check("out bus", 16'(output_bus), 16'h5A);
      end
      read_instr = 1'b0;
   endtask
   // Decode table ends in halt, which then raises a request
   task automatic t_decode;
      int i;
      logic [2:0] codes [8];
      codes = '{cbr_pkg::ST_T1, cbr_pkg::ST_T2, cbr_pkg::ST_T3, cbr_pkg::ST_T4,
                cbr_pkg::ST_T5, cbr_pkg::ST_ACK, cbr_pkg::ST_WAIT, cbr_pkg::ST_HALT};
      for (i = 0; i < 8; i++) begin
         step(codes[i], 8'h00);
         check("decode", 16'(timing_state), 16'(8'h01 << (i == 6 ? 7 : i == 7 ? 6 : i)));
      end
      irq_seq(3'h6, 8'h35);
   endtask
   task automatic t_ext;
      int r;
      for (r = 0; r < 8; r++) begin
         ext_irq_n = 1'b0;
         step(cbr_pkg::ST_T4, 8'h00);
         ext_irq_n = 1'b1;
         irq_seq(3'(r), {2'h0, 3'(r), 3'h5});
      end
   endtask
   task automatic t_poc;
      ext_irq_n = 1'b0;
      step(cbr_pkg::ST_T4, 8'h00);
      step(cbr_pkg::ST_T4, 8'h00);
      power_on_clear = 1'b1;
      repeat (40) @(negedge clk);
      check("poc clear", 16'(cpu_interrupt), 16'h0);
      power_on_clear = 1'b0;
      ext_irq_n = 1'b1;
      irq_seq(3'h4, 8'h2D);
   endtask

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      #(40 * 20000);
      n_mismatch++;
      give_verdict;
   end
   initial begin
      {rstn, read_instr, power_on_clear, state_code, cpu_data_out, input_bus} = '0;
      {processor_owns_bus, foreign_master_n, ext_irq_n} = 3'h7;
      restart_select_n = 3'h0;
      repeat (10) @(negedge clk);
      check("reset addr", 16'(address_bus_out), 16'h0000);
      check("reset strobe", 16'(interrupt_sample_strobe), 16'h1);
      check("ready", 16'(cpu_ready), 16'h1);
      rstn = 1'b1;
      @(negedge clk);
      // Reset arms the power-on source, so its interrupt comes first
      irq_seq(3'h2, 8'h1D);
      t_bus;
      t_own;
      t_decode;
      t_ext;
      t_poc;
      give_verdict;
   end
endmodule
bind cbr_bus_glue cbr_chk #(.ADDR_W(ADDR_W)) chk (.*);
`default_nettype wire
